/* orx_defines.svh */
/*
 * Constants for the OR and move instruction executor.
 * Assumes 14-bit instruction words and an 8-bit data path.
 */
`ifndef ORX_DEFINES_SVH
`define ORX_DEFINES_SVH

// =====================================================================
// Opcode fields
// =====================================================================
`define ORX_OP_HI       13
`define ORX_OP_LO       8
`define ORX_DEST_BIT    7
`define ORX_ADDR_HI     6
`define ORX_OP_IOR      6'h04
`define ORX_OP_MOVE_FILE     6'h08
`define ORX_OP_MOVE_WORKING_TO_FILE    6'h00
`define ORX_W_RESET     8'h00
`define ORX_Z_RESET     1'h0

`endif

/* orx_pkg.sv */
/*
 * Types for the OR and move instruction executor.
 * Assumes orx_defines.svh is compiled alongside.
 */
`default_nettype none

package orx_pkg;

    // =================================================================
    // Decoded operation
    // =================================================================
    typedef enum logic [1:0] {
        ORX_NONE = 2'b00,
        ORX_IOR  = 2'b01,
        ORX_MOVE_FILE = 2'b10,
        ORX_MOVW = 2'b11
    } orx_op_t;

endpackage : orx_pkg
`default_nettype wire

/* orx_decode.sv */
/*
 * Combinational decoder of one 14-bit instruction word.
 * Assumes the word is stable while the valid strobe is high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "orx_defines.svh"

module orx_decode (
    input  wire logic [13:0]    instr_in,
    output orx_pkg::orx_op_t    op_out,
    output logic                dest_out,
    output logic [6:0]          addr_out
);

    // =================================================================
    // Field split and opcode match
    // =================================================================
    // Opcode bits pick the operation; moves of W need bit 7 set.
    always_comb begin
        addr_out = instr_in[`ORX_ADDR_HI:0];
        dest_out = instr_in[`ORX_DEST_BIT];
        op_out   = orx_pkg::ORX_NONE;
        if (instr_in[`ORX_OP_HI:`ORX_OP_LO] == `ORX_OP_IOR) begin
            op_out = orx_pkg::ORX_IOR;
        end else if (instr_in[`ORX_OP_HI:`ORX_OP_LO] == `ORX_OP_MOVE_FILE) begin
            op_out = orx_pkg::ORX_MOVE_FILE;
        end else if (instr_in[`ORX_OP_HI:`ORX_OP_LO] == `ORX_OP_MOVE_WORKING_TO_FILE &&
                     instr_in[`ORX_DEST_BIT]) begin
            op_out = orx_pkg::ORX_MOVW;
        end
    end

endmodule : orx_decode
`default_nettype wire

/* orx_exec.sv */
/*
 * Executor for OR of W with a file register, move of a file register
 * and move of W to a file register.
 * Assumes the file space answers reads combinationally on the same
 * cycle and takes a write on the next clock edge.
 */
// Function
// - OR W with file, update zero
// - Destination bit selects W or file
// - Move file to W or back
// - Move file sets zero from value
// - Move W to file, flags untouched
`timescale 1ns/1ps
`default_nettype none
`include "orx_defines.svh"

module orx_exec (
    input  wire logic        CLOCK_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic        INSTR_VALID_IN,
    input  wire logic [13:0] INSTR_IN,
    input  wire logic [7:0]  FILE_RDATA_IN,
    output logic [6:0]       FILE_ADDR_OUT,
    output logic             FILE_WE_OUT,
    output logic [7:0]       FILE_WDATA_OUT,
    output logic [7:0]       W_OUT,
    output logic             ZERO_OUT,
    output logic             ZERO_WE_OUT,
    output logic             DONE_OUT
);

    // Decoded fields, the shared result and the registered state.
    orx_pkg::orx_op_t op;
    logic             dest;
    logic [6:0]       addr;
    logic [7:0]       result;
    logic [7:0]       w_reg;
    logic [7:0]       w_next;
    logic             z_reg;
    logic             z_next;
    logic             zwe_reg;
    logic             zwe_next;
    logic             done_reg;
    logic             done_next;

    // All checks below sample on the core clock and rest in reset.
    default clocking cb_core @(posedge CLOCK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    // =================================================================
    // Decode
    // =================================================================
    // The decoder splits the word and names the operation.
    orx_decode u_dec (
        .instr_in (INSTR_IN),
        .op_out   (op),
        .dest_out (dest),
        .addr_out (addr)
    );

    // =================================================================
    // Data path
    // =================================================================
    // Result per operation; file side is written in the same cycle.
    // The file read is combinational, so a word fits in one cycle.
    always_comb begin
        result = FILE_RDATA_IN;
        unique case (op)
            orx_pkg::ORX_IOR:  result = w_reg | FILE_RDATA_IN;
            orx_pkg::ORX_MOVE_FILE: result = FILE_RDATA_IN;
            orx_pkg::ORX_MOVW: result = w_reg;
            orx_pkg::ORX_NONE: result = FILE_RDATA_IN;
        endcase
    end

    // File port: address from the low seven bits, write when asked.
    // The strobe stays combinational; the file latches on the next edge.
    always_comb begin
        FILE_ADDR_OUT  = addr;
        FILE_WDATA_OUT = result;
        FILE_WE_OUT    = INSTR_VALID_IN &&
                         ((op == orx_pkg::ORX_MOVW) ||
                          (op != orx_pkg::ORX_NONE && dest));
    end

    // Next state of W, the zero flag and the completion pulse.
    // Only the OR and the move of a file touch the zero flag.
    always_comb begin
        w_next    = w_reg;
        z_next    = z_reg;
        zwe_next  = 1'b0;
        done_next = INSTR_VALID_IN && op != orx_pkg::ORX_NONE;
        if (INSTR_VALID_IN &&
            (op == orx_pkg::ORX_IOR || op == orx_pkg::ORX_MOVE_FILE)) begin
            z_next   = (result == 8'h00);
            zwe_next = 1'b1;
            if (!dest) begin
                w_next = result;
            end
        end
    end

    // Register the state; reset loads the power-up values.
    // W and Z hold between words, so refused words change nothing.
    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            w_reg    <= `ORX_W_RESET;
            z_reg    <= `ORX_Z_RESET;
            zwe_reg  <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            w_reg    <= w_next;
            z_reg    <= z_next;
            zwe_reg  <= zwe_next;
            done_reg <= done_next;
        end
    end

    // Registered state drives the outputs directly.
    assign W_OUT       = w_reg;
    assign ZERO_OUT    = z_reg;
    assign ZERO_WE_OUT = zwe_reg;
    assign DONE_OUT    = done_reg;

    // =================================================================
    // Checks
    // =================================================================
    // Each kind of word is named once and shared by its checks.
    sequence s_or_to_w;
        INSTR_VALID_IN && op == orx_pkg::ORX_IOR && !dest;
    endsequence

    sequence s_or_to_file;
        INSTR_VALID_IN && op == orx_pkg::ORX_IOR && dest;
    endsequence

    sequence s_move_file_to_w;
        INSTR_VALID_IN && op == orx_pkg::ORX_MOVE_FILE && !dest;
    endsequence

    sequence s_move_file_to_file;
        INSTR_VALID_IN && op == orx_pkg::ORX_MOVE_FILE && dest;
    endsequence

    sequence s_movw;
        INSTR_VALID_IN && op == orx_pkg::ORX_MOVW;
    endsequence

    sequence s_refused;
        INSTR_VALID_IN && op == orx_pkg::ORX_NONE;
    endsequence

    // The cycle after a word that must not touch the zero flag.
    sequence s_zero_kept;
        !ZERO_WE_OUT && $stable(ZERO_OUT);
    endsequence

    // OR into W leaves the OR of the old W and the file value in W.
    AST_OR_W: assert property (
        s_or_to_w |=> W_OUT == ($past(w_reg) | $past(FILE_RDATA_IN)))
        else $error("OR result not in W.");

    // Either destination of the OR pulses the zero write with a fresh test.
    AST_OR_ZERO: assert property (
        INSTR_VALID_IN && op == orx_pkg::ORX_IOR |=>
        ZERO_WE_OUT &&
        ZERO_OUT == (($past(w_reg) | $past(FILE_RDATA_IN)) == 8'h00))
        else $error("OR zero flag wrong.");

    // OR into the file writes the OR at once and keeps W.
    AST_DEST_FILE: assert property (
        s_or_to_file |->
        FILE_WE_OUT && FILE_WDATA_OUT == (W_OUT | FILE_RDATA_IN) ##1
        $stable(W_OUT))
        else $error("OR to file misrouted.");

    // Move to W skips the file write and loads W on the next edge.
    AST_MOVE_FILE_W: assert property (
        s_move_file_to_w |-> !FILE_WE_OUT ##1 W_OUT == $past(FILE_RDATA_IN))
        else $error("Move to W failed.");

    // Move back to the file rewrites the value it read and keeps W.
    AST_MOVE_FILE_FILE: assert property (
        s_move_file_to_file |->
        FILE_WE_OUT && FILE_WDATA_OUT == FILE_RDATA_IN ##1 $stable(W_OUT))
        else $error("Move back to file wrong.");

    // Either destination of the move tests the moved value for zero.
    AST_MOVE_FILE_Z: assert property (
        INSTR_VALID_IN && op == orx_pkg::ORX_MOVE_FILE |=>
        ZERO_WE_OUT && ZERO_OUT == ($past(FILE_RDATA_IN) == 8'h00))
        else $error("Move zero flag wrong.");

    // Move of W writes W to the file and leaves the zero flag alone.
    AST_MOVW: assert property (
        s_movw |-> FILE_WE_OUT && FILE_WDATA_OUT == W_OUT ##1 s_zero_kept)
        else $error("Move of W wrong.");

    // Move of W never changes W itself.
    AST_MOVW_KEEP_W: assert property (
        s_movw |=> $stable(W_OUT))
        else $error("Move of W changed W.");

    // Every known word finishes in one cycle at its low-seven-bit address.
    AST_ONE_CYCLE: assert property (
        INSTR_VALID_IN && op != orx_pkg::ORX_NONE |->
        FILE_ADDR_OUT == INSTR_IN[6:0] ##1 DONE_OUT)
        else $error("Not done in one cycle.");

    // An unknown word leaves the file, W and the flags untouched.
    AST_REFUSED: assert property (
        s_refused |-> !FILE_WE_OUT ##1
        !DONE_OUT && !ZERO_WE_OUT && $stable(W_OUT) && $stable(ZERO_OUT))
        else $error("Unknown word had an effect.");

    // With no word present nothing is written or signalled.
    AST_IDLE: assert property (
        !INSTR_VALID_IN |->
        !FILE_WE_OUT ##1 !DONE_OUT && !ZERO_WE_OUT && $stable(W_OUT))
        else $error("Activity without instruction.");

endmodule : orx_exec
`default_nettype wire

/* tb_or_move_instruction_exec.sv */
/*
 * Self-checking testbench for the OR and move instruction executor.
 * Assumes orx_defines.svh, orx_pkg.sv, orx_decode.sv and orx_exec.sv
 * are compiled before this file.
 */
`timescale 1ns/1ps
`default_nettype none
`include "orx_defines.svh"

module tb_or_move_instruction_exec;

    // =================================================================
    // Stimulus, reference state and counters
    // =================================================================
    logic        clock_in   = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        valid_in   = 1'b0;
    logic [13:0] instr_in   = 14'h0000;
    logic [7:0]  rdata_in   = 8'h00;
    logic [6:0]  addr_out;
    logic        we_out;
    logic [7:0]  wdata_out;
    logic [7:0]  w_out;
    logic        zero_out;
    logic        zero_we_out;
    logic        done_out;
    logic [7:0]  w_m    = 8'h00;
    logic        z_m    = 1'b0;
    logic        zwe_m  = 1'b0;
    logic        done_m = 1'b0;
    int          err_total  = 0;
    int          n_compared = 0;

    // The clock toggles every half period of 50 ns.
    always #50 clock_in = ~clock_in;

    orx_exec dut (
        .CLOCK_IN       (clock_in),
        .SYS_RST_IN     (sys_rst_in),
        .INSTR_VALID_IN (valid_in),
        .INSTR_IN       (instr_in),
        .FILE_RDATA_IN  (rdata_in),
        .FILE_ADDR_OUT  (addr_out),
        .FILE_WE_OUT    (we_out),
        .FILE_WDATA_OUT (wdata_out),
        .W_OUT          (w_out),
        .ZERO_OUT       (zero_out),
        .ZERO_WE_OUT    (zero_we_out),
        .DONE_OUT       (done_out)
    );

    // =================================================================
    // Compare tasks and the closing task
    // =================================================================
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp,
                        input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp8

    task automatic cmp1(input logic got, input logic exp, input string what);
        cmp8({7'h00, got}, {7'h00, exp}, what);
    endtask : cmp1

    task automatic finish_test();
        $display("errors %0d compared %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // Issues one word and checks the previous word's registered results.
    task automatic step(input logic vld, input logic [13:0] ins,
                        input logic [7:0] rd);
        logic [7:0] res;
        logic       hit;
        logic       mvw;
        @(posedge clock_in);
        valid_in <= vld;
        instr_in <= ins;
        rdata_in <= rd;
        @(negedge clock_in);
        cmp8(w_out, w_m, "working register");
        cmp1(zero_out, z_m, "zero flag");
        cmp1(zero_we_out, zwe_m, "zero write pulse");
        cmp1(done_out, done_m, "done pulse");
        cmp8({1'b0, addr_out}, {1'b0, ins[6:0]}, "file address");
        res = (ins[13:8] == 6'h04) ? (w_m | rd) : rd;
        hit = vld && (ins[13:8] == 6'h04 || ins[13:8] == 6'h08);
        mvw = vld && (ins[13:7] == 7'h01);
        cmp1(we_out, (hit && ins[7]) || mvw, "file write");
        if ((hit && ins[7]) || mvw) begin
            cmp8(wdata_out, hit ? res : w_m, "write data");
        end
        zwe_m = hit;
        done_m = hit || mvw;
        if (hit) z_m = (res == 8'h00);
        if (hit && !ins[7]) w_m = res;
    endtask : step

    // =================================================================
    // Scenarios
    // =================================================================
    // OR into W and into the file; the idle word judges the last one.
    task automatic t_or();
        step(1'b1, 14'h0813, 8'h91);
        step(1'b1, 14'h0413, 8'h13);
        step(1'b1, 14'h0493, 8'h40);
        step(1'b0, 14'h0000, 8'h00);
    endtask : t_or

    // Moves of a file to W and back, with zero and non-zero values.
    task automatic t_move_file();
        step(1'b1, 14'h0893, 8'h00);
        step(1'b1, 14'h0820, 8'h00);
        step(1'b1, 14'h0420, 8'h00);
        step(1'b1, 14'h08A0, 8'h5A);
        step(1'b0, 14'h0000, 8'h00);
    endtask : t_move_file

    // Moves of W after the zero flag was set, which must stay set.
    task automatic t_move_working_to_file();
        step(1'b1, 14'h0805, 8'h4F);
        step(1'b1, 14'h08C5, 8'h00);
        step(1'b1, 14'h00FF, 8'hFF);
        step(1'b1, 14'h0080, 8'h11);
        step(1'b0, 14'h0000, 8'h00);
    endtask : t_move_working_to_file

    // Unknown words and words without the valid strobe do nothing.
    task automatic t_refused();
        step(1'b1, 14'h0013, 8'h00);
        step(1'b1, 14'h0A93, 8'h00);
        step(1'b0, 14'h0093, 8'h00);
        step(1'b0, 14'h0000, 8'h00);
    endtask : t_refused

    // Mid-run reset clears W and the flags, then an OR runs from there.
    task automatic t_reset();
        @(posedge clock_in);
        sys_rst_in <= 1'b1;
        valid_in   <= 1'b0;
        @(negedge clock_in);
        cmp8(w_out, `ORX_W_RESET, "W in reset");
        cmp1(zero_out, `ORX_Z_RESET, "zero in reset");
        cmp1(zero_we_out, 1'b0, "zero pulse in reset");
        cmp1(done_out, 1'b0, "done in reset");
        cmp1(we_out, 1'b0, "file write in reset");
        repeat (2) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        w_m    = `ORX_W_RESET;
        z_m    = `ORX_Z_RESET;
        zwe_m  = 1'b0;
        done_m = 1'b0;
        step(1'b1, 14'h0413, 8'h13);
        step(1'b0, 14'h0000, 8'h00);
    endtask : t_reset

    // Reset for five cycles, then run the scenarios back to back.
    initial begin
        repeat (5) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        t_or();
        t_move_file();
        t_move_working_to_file();
        t_refused();
        t_reset();
        finish_test();
    end

    // Watchdog cuts a hang short well beyond the expected run length.
    initial begin
        #(200 * 100);
        err_total++;
        finish_test();
    end

endmodule : tb_or_move_instruction_exec

`default_nettype wire
